// File: verilog/aacr_top.sv
// Control registers of a digital audio amplifier on classic Wishbone.
// Assumes one 250 MHz clock and a rate family from the clock detector.
//
// Function
// - Low nibble selects format and word length
// - Format resets to I2S 24-bit
// - Shutdown bit set means hard mute
// - Shutdown bit set at reset
// - Bit 3 picks three-level sub-channel modulation
// - Bit 2 picks single-ended plus bridged sub
// - Bit 1 turns address pin into fault
// - Soft mute bits force 50% duty
// - Volume code steps half a dB down
// - 0x00 +24dB, 0x30 0dB, 0xFF mute
// - Master resets muted, channels at 0 dB
// - Ramp step count from config bits 2:0
// - Step count governs volume and mute ramps
// - Step rate follows sample rate family
// - Bit 6 picks sub volume source
// - Bit 5 picks channel 3 volume source
// - Duty limit code caps PWM duty
//
// Chosen here: register access over Wishbone.
`timescale 1ns/100ps
module aacr_top #(
    parameter int STEP_CYC_8K = aacr_pkg::STEP_CYC_8K,
    parameter int STEP_CYC_11K = aacr_pkg::STEP_CYC_11K,
    parameter int STEP_CYC_12K = aacr_pkg::STEP_CYC_12K
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Sample rate family from the clock detector
    input wire logic [1:0] fs_family_i,
    // Serial input format
    output aacr_pkg::aacr_fmt_s fmt_o,
    output logic fmt_reserved_o,
    // Power stage control
    output logic shutdown_o,
    output logic midz_ramp_o,
    output logic three_level_modulation_o,
    output logic single_ended_output_o,
    output logic bridged_output_o,
    output logic fault_out_en_o,
    // Per-channel soft mute: ch1, ch2, ch3, sub
    output logic [3:0] soft_mute_o,
    // Ramped volume codes: master, then ch1, ch2, ch3, sub
    output logic [7:0] master_level_o,
    output logic [3:0][7:0] chan_level_o,
    output logic ramp_busy_o,
    output logic [11:0] ramp_steps_o,
    // Duty cap in 1/256 of the period
    output logic [7:0] duty_cap_o
);

    // Stored registers, writable bits only
    logic [3:0] format_r; // Serial format code
    logic [7:0] sysctl2_r; // System control two
    logic [2:0] soft_mute_r; // Soft mute per channel
    logic [7:0] master_vol_r; // Master volume code
    logic [7:0] ch1_vol_r; // Channel one code
    logic [7:0] ch2_vol_r; // Channel two code
    logic [7:0] ch3_vol_r; // Channel three code
    logic [7:0] ramp_cfg_r; // Ramp configuration
    logic [2:0] duty_lim_r; // Duty limit code
    logic [1:0] ramp_sel_r; // Last valid ramp code

    // Bus decode
    logic [5:0] idx; // Register index
    logic req; // New request this cycle
    logic wr_en; // Write to low byte lane
    logic [7:0] rd_byte; // Read mux result
    logic [7:0] wb; // Written byte

    // Ramp plumbing
    logic tick; // One ramp step
    logic [3:0] inc; // Step size in level eighths
    logic [4:0][7:0] tgt; // Targets: master, ch1..ch3, sub
    logic [4:0][7:0] lvl; // Ramped levels
    logic [4:0] busy; // Ramps in motion

    assign idx = adr_i[7:2];
    assign wb = dat_i[7:0];
    // Ack toggles back low so each request gets exactly one ack
    assign req = cyc_i && stb_i && !ack_o;
    assign wr_en = req && we_i && sel_i[0];

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // Read mux; unmapped indices read zero and still ack
    always_comb begin
        case (idx)
            aacr_pkg::IDX_FORMAT: rd_byte = {4'h0, format_r};
            aacr_pkg::IDX_SYSCTL2: rd_byte = sysctl2_r;
            aacr_pkg::IDX_SOFT_MUTE: rd_byte = {5'h00, soft_mute_r};
            aacr_pkg::IDX_MASTER_VOL: rd_byte = master_vol_r;
            aacr_pkg::IDX_CH1_VOL: rd_byte = ch1_vol_r;
            aacr_pkg::IDX_CH2_VOL: rd_byte = ch2_vol_r;
            aacr_pkg::IDX_CH3_VOL: rd_byte = ch3_vol_r;
            aacr_pkg::IDX_RAMP_CFG: rd_byte = ramp_cfg_r;
            aacr_pkg::IDX_DUTY_LIMIT: rd_byte = {5'h00, duty_lim_r};
            default: rd_byte = 8'h00;
        endcase
    end

    // Read data registered with the ack; upper bytes always zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (req && !we_i) begin
            dat_o <= {24'h000000, rd_byte};
        end else begin
            dat_o <= 32'h0;
        end
    end

    // Serial format; upper nibble is not stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            format_r <= aacr_pkg::FORMAT_RST;
        end else if (wr_en && idx == aacr_pkg::IDX_FORMAT) begin
            format_r <= wb[3:0];
        end
    end

    // System control two; shutdown set from reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sysctl2_r <= aacr_pkg::SYSCTL2_RST;
        end else if (wr_en && idx == aacr_pkg::IDX_SYSCTL2) begin
            sysctl2_r <= wb & aacr_pkg::SC2_MASK;
        end
    end

    // Soft mute per channel
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_mute_r <= aacr_pkg::SOFT_MUTE_RST;
        end else if (wr_en && idx == aacr_pkg::IDX_SOFT_MUTE) begin
            soft_mute_r <= wb[2:0];
        end
    end

    // Volume registers; master starts muted, channels at 0 dB
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_vol_r <= aacr_pkg::VOL_MUTE;
            ch1_vol_r <= aacr_pkg::VOL_0DB;
            ch2_vol_r <= aacr_pkg::VOL_0DB;
            ch3_vol_r <= aacr_pkg::VOL_0DB;
        end else if (wr_en) begin
            case (idx)
                aacr_pkg::IDX_MASTER_VOL: master_vol_r <= wb;
                aacr_pkg::IDX_CH1_VOL: ch1_vol_r <= wb;
                aacr_pkg::IDX_CH2_VOL: ch2_vol_r <= wb;
                aacr_pkg::IDX_CH3_VOL: ch3_vol_r <= wb;
                default: ;
            endcase
        end
    end

    // Ramp configuration; the source bits are stored even if the host
    // breaks the mute precondition, so readback stays truthful
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ramp_cfg_r <= aacr_pkg::RAMP_CFG_RST;
        end else if (wr_en && idx == aacr_pkg::IDX_RAMP_CFG) begin
            ramp_cfg_r <= wb & aacr_pkg::RC_MASK;
        end
    end

    // Reserved step codes leave the last valid step count in force
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ramp_sel_r <= aacr_pkg::RAMP_CFG_RST[1:0];
        end else if (wr_en && idx == aacr_pkg::IDX_RAMP_CFG
                     && !wb[aacr_pkg::RC_RESERVED]) begin
            ramp_sel_r <= wb[1:0];
        end
    end

    // Duty limit code
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            duty_lim_r <= aacr_pkg::DUTY_LIMIT_RST;
        end else if (wr_en && idx == aacr_pkg::IDX_DUTY_LIMIT) begin
            duty_lim_r <= wb[2:0];
        end
    end

    // Format decode; reserved codes keep the previous format
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fmt_o.mode <= aacr_pkg::AACR_I2S;
            fmt_o.word_len <= 5'd24;
            fmt_reserved_o <= 1'b0;
        end else begin
            fmt_reserved_o <= (format_r > aacr_pkg::FORMAT_LAST_VALID);
            case (format_r)
                4'h0: fmt_o <= {aacr_pkg::AACR_RIGHT_JUST, 5'd16};
                4'h1: fmt_o <= {aacr_pkg::AACR_RIGHT_JUST, 5'd20};
                4'h2: fmt_o <= {aacr_pkg::AACR_RIGHT_JUST, 5'd24};
                4'h3: fmt_o <= {aacr_pkg::AACR_I2S, 5'd16};
                4'h4: fmt_o <= {aacr_pkg::AACR_I2S, 5'd20};
                4'h5: fmt_o <= {aacr_pkg::AACR_I2S, 5'd24};
                4'h6: fmt_o <= {aacr_pkg::AACR_LEFT_JUST, 5'd16};
                4'h7: fmt_o <= {aacr_pkg::AACR_LEFT_JUST, 5'd20};
                4'h8: fmt_o <= {aacr_pkg::AACR_LEFT_JUST, 5'd24};
                default: fmt_o <= fmt_o;
            endcase
        end
    end

    // Power stage controls from system control two
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shutdown_o <= 1'b1;
            midz_ramp_o <= 1'b0;
            three_level_modulation_o <= 1'b0;
            single_ended_output_o <= 1'b0;
            bridged_output_o <= 1'b1;
            fault_out_en_o <= 1'b0;
        end else begin
            shutdown_o <= sysctl2_r[aacr_pkg::SC2_SHUTDOWN];
            midz_ramp_o <= sysctl2_r[aacr_pkg::SC2_MIDZ];
            three_level_modulation_o <=
                sysctl2_r[aacr_pkg::SC2_THREE_LEVEL];
            single_ended_output_o <=
                sysctl2_r[aacr_pkg::SC2_TOPOLOGY];
            bridged_output_o <= !sysctl2_r[aacr_pkg::SC2_TOPOLOGY];
            fault_out_en_o <= sysctl2_r[aacr_pkg::SC2_FAULT_PIN];
        end
    end

    // Step count and step size: the whole code range of 256 always
    // spans the configured number of steps, whatever the endpoints
    always_comb begin
        case (ramp_sel_r)
            2'h0: inc = 4'h4;
            2'h1: inc = 4'h2;
            2'h2: inc = 4'h1;
            default: inc = 4'h8;
        endcase
    end

    // Published step count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ramp_steps_o <= aacr_pkg::RAMP_STEPS_1;
        end else begin
            case (ramp_sel_r)
                2'h0: ramp_steps_o <= aacr_pkg::RAMP_STEPS_0;
                2'h1: ramp_steps_o <= aacr_pkg::RAMP_STEPS_1;
                2'h2: ramp_steps_o <= aacr_pkg::RAMP_STEPS_2;
                default: ramp_steps_o <= aacr_pkg::RAMP_STEPS_3;
            endcase
        end
    end

    // Duty cap: each code lowers the cap by two 256ths
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            duty_cap_o <= aacr_pkg::DUTY_CAP_TOP
                - 8'(aacr_pkg::DUTY_CAP_DROP * aacr_pkg::DUTY_LIMIT_RST);
        end else begin
            duty_cap_o <= aacr_pkg::DUTY_CAP_TOP
                - 8'(aacr_pkg::DUTY_CAP_DROP * duty_lim_r);
        end
    end

    // Volume sources; the selectors are sampled live, relying on the
    // host to flip them only while master is muted to avoid steps
    always_comb begin
        tgt[0] = master_vol_r;
        tgt[1] = ch1_vol_r;
        tgt[2] = ch2_vol_r;
        // Channel three follows channel two unless told otherwise
        if (ramp_cfg_r[aacr_pkg::RC_CH3_SRC]) begin
            tgt[3] = ch3_vol_r;
        end else begin
            tgt[3] = ch2_vol_r;
        end
        // Sub follows channel one unless told otherwise
        if (ramp_cfg_r[aacr_pkg::RC_SUB_SRC]) begin
            tgt[4] = ch3_vol_r;
        end else begin
            tgt[4] = ch1_vol_r;
        end
    end

    // Shared step timer tied to the sample rate family
    aacr_step_tick #(
        .CYC_8K(STEP_CYC_8K),
        .CYC_11K(STEP_CYC_11K),
        .CYC_12K(STEP_CYC_12K)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fs_family_i(fs_family_i),
        .tick_o(tick)
    );

    // One ramp per volume path; codes are half-dB steps downward
    for (genvar g = 0; g < 5; g++) begin : g_ramp
        aacr_vol_ramp #(
            .RST_CODE(g == 0 ? aacr_pkg::VOL_MUTE : aacr_pkg::VOL_0DB)
        ) u_ramp (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .tick_i(tick),
            .target_i(tgt[g]),
            .inc_i(inc),
            .level_o(lvl[g]),
            .busy_o(busy[g])
        );
    end

    // Levels to the ports; a channel ramp that reached 0xFF is a soft mute
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_level_o <= aacr_pkg::VOL_MUTE;
            chan_level_o <= {4{aacr_pkg::VOL_0DB}};
            ramp_busy_o <= 1'b0;
        end else begin
            master_level_o <= lvl[0];
            chan_level_o <= {lvl[4], lvl[3], lvl[2], lvl[1]};
            ramp_busy_o <= |busy;
        end
    end

    // Soft mute: register bit or a channel code resting at mute;
    // sub shares the channel three mute bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_mute_o <= 4'h0;
        end else begin
            soft_mute_o[0] <= soft_mute_r[0]
                || lvl[1] == aacr_pkg::VOL_MUTE;
            soft_mute_o[1] <= soft_mute_r[1]
                || lvl[2] == aacr_pkg::VOL_MUTE;
            soft_mute_o[2] <= soft_mute_r[2]
                || lvl[3] == aacr_pkg::VOL_MUTE;
            soft_mute_o[3] <= soft_mute_r[2]
                || lvl[4] == aacr_pkg::VOL_MUTE;
        end
    end

endmodule

// File: inc/aacr_pkg.sv
// Package for the audio amplifier control register block.
// Assumes a 250 MHz system clock and a 32-bit classic Wishbone bus.
package aacr_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_FORMAT = 6'h04;
    localparam logic [5:0] IDX_SYSCTL2 = 6'h05;
    localparam logic [5:0] IDX_SOFT_MUTE = 6'h06;
    localparam logic [5:0] IDX_MASTER_VOL = 6'h07;
    localparam logic [5:0] IDX_CH1_VOL = 6'h08;
    localparam logic [5:0] IDX_CH2_VOL = 6'h09;
    localparam logic [5:0] IDX_CH3_VOL = 6'h0a;
    localparam logic [5:0] IDX_RAMP_CFG = 6'h0e;
    localparam logic [5:0] IDX_DUTY_LIMIT = 6'h10;

    // Reset values
    localparam logic [3:0] FORMAT_RST = 4'h5;
    localparam logic [7:0] SYSCTL2_RST = 8'h40;
    localparam logic [2:0] SOFT_MUTE_RST = 3'h0;
    localparam logic [7:0] VOL_MUTE = 8'hff;
    localparam logic [7:0] VOL_0DB = 8'h30;
    localparam logic [7:0] RAMP_CFG_RST = 8'h01;
    localparam logic [2:0] DUTY_LIMIT_RST = 3'h2;

    // Field positions
    localparam int SC2_MIDZ = 7;
    localparam int SC2_SHUTDOWN = 6;
    localparam int SC2_THREE_LEVEL = 3;
    localparam int SC2_TOPOLOGY = 2;
    localparam int SC2_FAULT_PIN = 1;
    localparam int RC_SUB_SRC = 6;
    localparam int RC_CH3_SRC = 5;
    localparam int RC_RESERVED = 2;

    // Writable bits per register, the rest read as zero; last valid format code
    localparam logic [7:0] SC2_MASK = 8'hce;
    localparam logic [7:0] RC_MASK = 8'h67;
    localparam logic [3:0] FORMAT_LAST_VALID = 4'h8;

    // Ramp steps for codes 0..3
    localparam logic [11:0] RAMP_STEPS_0 = 12'h200;
    localparam logic [11:0] RAMP_STEPS_1 = 12'h400;
    localparam logic [11:0] RAMP_STEPS_2 = 12'h800;
    localparam logic [11:0] RAMP_STEPS_3 = 12'h100;

    // Duty cap in 1/256 units: top value, drop per code
    localparam logic [7:0] DUTY_CAP_TOP = 8'hfe;
    localparam logic [7:0] DUTY_CAP_DROP = 8'h02;

    // Ramp step times in ns, and the derived cycle counts
    localparam int CLK_PERIOD_NS = 4;
    localparam int STEP_NS_8K = 125000;
    localparam int STEP_NS_11K = 90700;
    localparam int STEP_NS_12K = 83300;
    localparam int STEP_CYC_8K = STEP_NS_8K / CLK_PERIOD_NS;
    localparam int STEP_CYC_11K = STEP_NS_11K / CLK_PERIOD_NS;
    localparam int STEP_CYC_12K = STEP_NS_12K / CLK_PERIOD_NS;

    // Fractional bits of the ramped level
    localparam int LVL_FRAC = 3;

    // Sample rate families
    typedef enum logic [1:0] {
        AACR_FS_8K = 2'h0,
        AACR_FS_11K = 2'h1,
        AACR_FS_12K = 2'h2
    } aacr_fs_e;

    // Serial justification modes
    typedef enum logic [1:0] {
        AACR_RIGHT_JUST = 2'h0,
        AACR_I2S = 2'h1,
        AACR_LEFT_JUST = 2'h2
    } aacr_mode_e;

    // Decoded serial input format
    typedef struct packed {
        aacr_mode_e mode;
        logic [4:0] word_len;
    } aacr_fmt_s;

endpackage

// File: verilog/aacr_step_tick.sv
// Volume ramp step timer: one pulse per ramp step.
// Assumes the sample rate family comes from logic on the same clock.
`timescale 1ns/100ps
module aacr_step_tick #(
    parameter int CYC_8K = aacr_pkg::STEP_CYC_8K,
    parameter int CYC_11K = aacr_pkg::STEP_CYC_11K,
    parameter int CYC_12K = aacr_pkg::STEP_CYC_12K
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] fs_family_i,
    output logic tick_o
);
    logic [16:0] cnt_r; // Cycles left to the next step
    logic [16:0] load; // Reload value for this family

    // Period picked from the rate family; unknown codes use the slowest
    always_comb begin
        case (fs_family_i)
            aacr_pkg::AACR_FS_11K: load = 17'(CYC_11K - 1);
            aacr_pkg::AACR_FS_12K: load = 17'(CYC_12K - 1);
            default: load = 17'(CYC_8K - 1);
        endcase
    end

    // Down counter; a family change takes effect at the next reload
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 17'h0;
            tick_o <= 1'b0;
        end else if (cnt_r == 17'h0) begin
            cnt_r <= load;
            tick_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r - 17'h1;
            tick_o <= 1'b0;
        end
    end
endmodule

// File: verilog/aacr_vol_ramp.sv
// One volume ramp: the level moves toward the target on step pulses.
// Assumes a one-cycle step pulse and a stable step size between pulses.
`timescale 1ns/100ps
module aacr_vol_ramp #(
    parameter logic [7:0] RST_CODE = aacr_pkg::VOL_0DB
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic [7:0] target_i,
    input wire logic [3:0] inc_i,
    output logic [7:0] level_o,
    output logic busy_o
);
    localparam int W = 8 + aacr_pkg::LVL_FRAC;
    logic [W-1:0] lvl_r; // Level with fractional bits
    logic [W-1:0] goal; // Target at the same scale
    logic [W-1:0] step; // Step size at the same scale

    assign goal = {target_i, {aacr_pkg::LVL_FRAC{1'b0}}};
    assign step = W'(inc_i);
    assign level_o = lvl_r[W-1:aacr_pkg::LVL_FRAC];
    assign busy_o = (lvl_r != goal);

    // Move by one step, clipped so the target is never overshot
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvl_r <= {RST_CODE, {aacr_pkg::LVL_FRAC{1'b0}}};
        end else if (tick_i && (lvl_r < goal)) begin
            if (goal - lvl_r > step) begin
                lvl_r <= lvl_r + step;
            end else begin
                lvl_r <= goal;
            end
        end else if (tick_i && (lvl_r > goal)) begin
            if (lvl_r - goal > step) begin
                lvl_r <= lvl_r - step;
            end else begin
                lvl_r <= goal;
            end
        end
    end
endmodule

// File: dv/aacr_top_props.sv
// Checker for the amplifier control register block.
// Assumes it is bound into aacr_top on its single clock.
`timescale 1ns/100ps
module aacr_top_props #(
    parameter int STEP_CYC_8K = 4,
    parameter int STEP_CYC_11K = 3,
    parameter int STEP_CYC_12K = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire aacr_pkg::aacr_fmt_s fmt_o,
    input wire logic shutdown_o,
    input wire logic three_level_modulation_o,
    input wire logic single_ended_output_o,
    input wire logic bridged_output_o,
    input wire logic fault_out_en_o,
    input wire logic [7:0] master_level_o,
    input wire logic [11:0] ramp_steps_o,
    input wire logic [7:0] duty_cap_o
);
    // Write taken at this edge with byte lane 0 on
    wire logic wr_take = cyc_i && stb_i && we_i && !ack_o && sel_i[0];

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_idle_data_zero:
        assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_upper_zero:
        assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read bytes not zero");
    a_ack_single:
        assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack not a single pulse after request");
    a_topology_pair:
        assert property (single_ended_output_o != bridged_output_o)
        else $error("topology outputs not complementary");
    // Decoded controls follow two edges after the write is taken
    a_sysctl_write:
        assert property (wr_take && adr_i[7:2] == aacr_pkg::IDX_SYSCTL2
            |-> ##2 {shutdown_o, three_level_modulation_o,
            single_ended_output_o, fault_out_en_o} ==
            {$past(dat_i[6], 2), $past(dat_i[3:1], 2)})
        else $error("system control outputs wrong after write");
    a_reset_state:
        assert property ($fell(rst_i) |-> shutdown_o &&
            master_level_o == 8'hff && fmt_o.word_len == 5'd24 &&
            ramp_steps_o == 12'h400 && duty_cap_o == 8'hfa)
        else $error("outputs wrong after reset");
    a_duty_write:
        assert property (wr_take && adr_i[7:2] == aacr_pkg::IDX_DUTY_LIMIT
            |-> ##2 duty_cap_o == 8'hfe - {4'h0, $past(dat_i[2:0], 2), 1'b0})
        else $error("duty cap wrong after write");
    // A ramp moves the level by one code at most per change
    a_level_slew:
        assert property (master_level_o != $past(master_level_o) |->
            8'(master_level_o - $past(master_level_o)) inside {8'h01, 8'hff})
        else $error("master level jumped");
endmodule

bind aacr_top aacr_top_props #(
    .STEP_CYC_8K(STEP_CYC_8K),
    .STEP_CYC_11K(STEP_CYC_11K),
    .STEP_CYC_12K(STEP_CYC_12K)
) u_aacr_top_props (.*);

// File: dv/aacr_host_model.sv
// Host controller model: classic Wishbone single cycles.
// Assumes the bench calls xfer and the slave acks each request.
`timescale 1ns/100ps
module aacr_host_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic [7:0] adr_o,
    output logic [31:0] dat_o,
    output logic [3:0] sel_o,
    output logic we_o,
    output logic cyc_o,
    output logic stb_o
);
    // Idle bus at time zero
    initial begin
        adr_o = 8'h00;
        dat_o = 32'h0;
        sel_o = 4'h0;
        we_o = 1'b0;
        cyc_o = 1'b0;
        stb_o = 1'b0;
    end

    // One transfer; request held until ack is seen
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        dat_o <= {24'h0, d};
        sel_o <= 4'hf;
        // Ack and read data are taken at the rising edge that samples ack
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Released address and data lines show junk, not the last value
        adr_o <= ~a;
        dat_o <= ~{24'h0, d};
    endtask
endmodule

// File: dv/aacr_top_test.sv
// Self-checking bench for the amplifier control registers.
// Assumes shortened ramp step counts of 4/3/2 cycles.
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    fails++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); \
    end end
module aacr_top_test;
    typedef struct packed {
        logic [7:0] adr;
        logic [7:0] wd;
        logic [7:0] rd;
        logic [7:0] rv;
    } aacr_row_s;
    // Address, write, readback, reset value
    aacr_row_s rows [10] = '{'{8'h10, 8'h09, 8'h09, 8'h05},
        '{8'h14, 8'hff, 8'hce, 8'h40}, '{8'h18, 8'hff, 8'h07, 8'h00},
        '{8'h38, 8'hff, 8'h67, 8'h01}, '{8'h20, 8'h00, 8'h00, 8'h30},
        '{8'h24, 8'hff, 8'hff, 8'h30}, '{8'h28, 8'h31, 8'h31, 8'h30},
        '{8'h40, 8'hff, 8'h07, 8'h02}, '{8'h46, 8'hff, 8'h00, 8'h00},
        '{8'h1c, 8'hfe, 8'hfe, 8'hff}};
    logic [4:0] lens [3] = '{5'd16, 5'd20, 5'd24};
    logic [11:0] st [4] = '{12'h200, 12'h400, 12'h800, 12'h100};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [1:0] fs_family_i = 2'h0;
    logic [31:0] q;
    int fails = 0;
    int comparisons = 0;
    int cyc_cnt = 0;
    wire logic [7:0] adr;
    wire logic [31:0] dat_w, dat_r;
    wire logic [3:0] sel, smute;
    wire logic we, cyc, stb, ack, fres, sd, midz, three, se, bridged_output, flt, busy;
    wire aacr_pkg::aacr_fmt_s fmt;
    wire logic [7:0] mlvl, duty;
    wire logic [3:0][7:0] clvl;
    wire logic [11:0] steps;

    aacr_host_model u_aacr_host_model (.clk_i(clk_i), .ack_i(ack),
        .dat_i(dat_r), .adr_o(adr), .dat_o(dat_w), .sel_o(sel),
        .we_o(we), .cyc_o(cyc), .stb_o(stb));
    aacr_top #(.STEP_CYC_8K(4), .STEP_CYC_11K(3), .STEP_CYC_12K(2))
    u_aacr_top (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat_w),
        .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(dat_r),
        .ack_o(ack), .fs_family_i(fs_family_i), .fmt_o(fmt),
        .fmt_reserved_o(fres), .shutdown_o(sd), .midz_ramp_o(midz),
        .three_level_modulation_o(three), .single_ended_output_o(se),
        .bridged_output_o(bridged_output), .fault_out_en_o(flt), .soft_mute_o(smute),
        .master_level_o(mlvl), .chan_level_o(clvl), .ramp_busy_o(busy),
        .ramp_steps_o(steps), .duty_cap_o(duty));

    // 250 MHz clock
    always #2 clk_i = ~clk_i;

    // Hang guard, well above the expected run
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Write, then let decoded outputs land
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        u_aacr_host_model.xfer(1'b1, a, d, r);
        @(negedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a);
        u_aacr_host_model.xfer(1'b0, a, 8'h00, q);
    endtask

    // Wait for every ramp to reach its target
    task automatic settle();
        repeat (3) @(negedge clk_i);
        while (busy !== 1'b0) @(negedge clk_i);
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // Table rows; master last so config changes while muted
        foreach (rows[i]) begin
            wr(rows[i].adr, rows[i].wd);
            rd(rows[i].adr);
            `CHK(q, {24'h0, rows[i].rd})
        end
        $display("register table test done");
        // Mid-run reset
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        `CHK({sd, bridged_output, duty, steps}, {2'b11, 8'hfa, 12'h400})
        `CHK(fmt, {aacr_pkg::AACR_I2S, 5'd24})
        `CHK({mlvl, clvl}, {8'hff, {4{8'h30}}})
        foreach (rows[i]) begin
            rd(rows[i].adr);
            `CHK(q, {24'h0, rows[i].rv})
        end
        $display("reset test done");
        for (int i = 0; i < 9; i++) begin
            wr(8'h10, 8'(i));
            `CHK(fmt, {2'(i / 3), lens[i % 3]})
        end
        // Reserved code keeps the last format
        wr(8'h10, 8'h0c);
        `CHK({fres, fmt}, {1'b1, 2'h2, 5'd24})
        wr(8'h14, 8'h8e);
        `CHK({midz, sd, three, se, bridged_output, flt}, 6'b101101)
        wr(8'h14, 8'h40);
        `CHK({midz, sd, three, se, bridged_output, flt}, 6'b010010)
        for (int i = 0; i < 4; i++) begin
            wr(8'h38, 8'(i));
            `CHK(steps, st[i])
        end
        wr(8'h38, 8'h04);
        `CHK(steps, 12'h100)
        for (int i = 0; i < 8; i++) begin
            wr(8'h40, 8'(i));
            `CHK(duty, 8'(8'hfe - 2 * i))
        end
        $display("decode test done");
        wr(8'h24, 8'h40);
        wr(8'h28, 8'h50);
        settle();
        `CHK({clvl[3], clvl[2]}, {8'h30, 8'h40})
        // Source bits changed while master is still muted
        wr(8'h38, 8'h63);
        settle();
        `CHK({clvl[3], clvl[2]}, {8'h50, 8'h50})
        @(posedge clk_i);
        fs_family_i <= 2'h2;
        wr(8'h1c, 8'h30);
        // About one code per two cycles with the shortened 12k period
        repeat (200) @(negedge clk_i);
        `CHK(mlvl inside {[8'h98:8'h9e]}, 1'b1)
        settle();
        `CHK(mlvl, 8'h30)
        wr(8'h18, 8'h05);
        @(negedge clk_i);
        `CHK(smute, 4'hd)
        wr(8'h18, 8'h00);
        @(posedge clk_i);
        fs_family_i <= 2'h1;
        wr(8'h20, 8'hff);
        settle();
        @(negedge clk_i);
        `CHK({clvl[0], smute[0]}, {8'hff, 1'b1})
        $display("volume test done");
        tally_and_finish();
    end
endmodule
